//--- tcpp_top.sv
// Purpose: 16-bit timer with capture, compare, edge and center pwm channels
// Assumes: AXI4-Lite slave on ref_clk; pins arrive asynchronously
// Notes: Channel pins routed to a default or alternate port pin
//
// Behaviour
// - One to eight channels, each capture, compare or edge pwm.
// - Selected capture edge copies counter into value register, sets flag.
// - Capture edge is rising, falling, either, or none which disables.
// - Compare match sets flag and clears, sets, toggles or ignores pin.
// - Edge pwm period is modulo plus one; value sets duty; polarity selectable.
// - Edge pwm offers period-end and duty-transition events.
// - All edge pwm leading edges align at the common period start.
// - One center select forces all channels to center pwm only.
// - Center pwm counts up to modulo then down to zero.
// - Center output active on down match, inactive on up match.
// - Debug mode stops all counting until normal mode returns.
// - Wait mode keeps counting and interrupts running.
// - Stop mode halts everything until clocks resume.
// - Clock from bus, fixed or external, then prescale 1 to 128.
// - Fixed clock is synchronised to the bus clock first.
// - Modulo 0x0000 or 0xFFFF means free running.
// - Counter reads never disturb counting.
// - Any counter write resets it.
// - One interrupt per channel plus one overflow interrupt.
// - Position bit 0 selects default pin, 1 the alternate pin.
// - Unused pins stay with general I/O; nothing enabled after reset.
// - External clock input may also feed another timer.
// - External clock is synchronised; at most a quarter bus rate.
// - Pin released when edge select or clock source is off.
// - Edge pwm high at zero, low on match; low select bit inverts.
// - Capture inputs synchronised; pulses need four bus clocks.
`timescale 1ns/1ps
module tcpp_top #(
    parameter int NUM_CH = 2
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic background_debug_mode,
    input wire logic fixed_clk,
    input wire logic external_count_clock,
    input wire logic [NUM_CH-1:0] pin_def_in,
    output logic [NUM_CH-1:0] pin_def_out,
    output logic [NUM_CH-1:0] pin_def_oe,
    input wire logic [NUM_CH-1:0] pin_alt_in,
    output logic [NUM_CH-1:0] pin_alt_out,
    output logic [NUM_CH-1:0] pin_alt_oe,
    output logic [NUM_CH-1:0] channel_irq,
    output logic overflow_irq,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // ========================================
    // Register state
    logic [2:0] presc_q;
    logic [1:0] clksel_q;
    logic center_q;
    logic ovf_ie_q;
    logic ovf_flag_q;
    logic [15:0] modulo_q;
    logic [NUM_CH-1:0] pinpos_q;
    tcpp_pkg::tcpp_ch_cfg_type ch_cfg_q [NUM_CH];
    logic [15:0] ch_value_q [NUM_CH];
    logic [NUM_CH-1:0] ch_flag_q;

    // ========================================
    // Bus write path
    logic [7:0] awaddr_q;
    logic aw_held_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic w_held_q;
    logic do_write;
    logic [31:0] wr_word;
    logic wr_ctrl;
    logic wr_count;
    logic wr_modulo;
    logic wr_pinpos;
    logic wr_known;

    assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
    assign s_axi_wready = !w_held_q && !s_axi_bvalid;
    assign do_write = aw_held_q && w_held_q;
    assign wr_ctrl = do_write && (awaddr_q == tcpp_pkg::OFF_CTRL);
    assign wr_count = do_write && (awaddr_q == tcpp_pkg::OFF_COUNT);
    assign wr_modulo = do_write && (awaddr_q == tcpp_pkg::OFF_MODULO);
    assign wr_pinpos = do_write && (awaddr_q == tcpp_pkg::OFF_PINPOS);

    // Byte lanes merged over the old value
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return res;
    endfunction

    // ========================================
    // Clock source and prescaler
    logic fixed_sync;
    logic ext_sync;
    logic fixed_prev_q;
    logic ext_prev_q;
    logic src_pulse;
    logic [6:0] pre_cnt_q;
    logic [6:0] pre_mask;
    logic tick;

    tcpp_sync #(.WIDTH(1)) u_sync_fixed (
        .ref_clk(ref_clk),
        .rst(rst),
        .ce(ce),
        .async_in(fixed_clk),
        .sync_out(fixed_sync)
    );

    tcpp_sync #(.WIDTH(1)) u_sync_ext (
        .ref_clk(ref_clk),
        .rst(rst),
        .ce(ce),
        .async_in(external_count_clock),
        .sync_out(ext_sync)
    );

    assign src_pulse = (clksel_q == tcpp_pkg::CLK_BUS) ||
        ((clksel_q == tcpp_pkg::CLK_FIXED) && fixed_sync && !fixed_prev_q) ||
        ((clksel_q == tcpp_pkg::CLK_EXT) && ext_sync && !ext_prev_q);
    assign pre_mask = 7'((8'h01 << presc_q) - 8'h01);
    assign tick = src_pulse && !background_debug_mode && ((pre_cnt_q & pre_mask) == pre_mask);

    // ========================================
    // Counter
    logic [15:0] count_q;
    logic down_q;
    logic advanced_q;
    logic [15:0] top;
    logic at_top;
    logic ovf_evt;
    tcpp_pkg::tcpp_cnt_type cnt_bus;

    // free run on 0x0000 or 0xFFFF
    assign top = (modulo_q == tcpp_pkg::RST_MODULO) ? tcpp_pkg::COUNT_FULL : modulo_q;
    assign at_top = (count_q == top);
    // period end events
    // Center mode flags at the turnaround from top, one event per period
    assign ovf_evt = tick && !wr_count && at_top;
    assign cnt_bus = '{count: count_q, advanced: advanced_q, down: down_q,
                       center: center_q, enabled: (clksel_q != tcpp_pkg::CLK_OFF)};

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            count_q <= tcpp_pkg::RST_COUNT;
            down_q <= 1'b0;
            advanced_q <= 1'b0;
            pre_cnt_q <= '0;
            fixed_prev_q <= 1'b0;
            ext_prev_q <= 1'b0;
        end else if (ce) begin
            fixed_prev_q <= fixed_sync;
            ext_prev_q <= ext_sync;
            advanced_q <= tick || wr_count;
            if (src_pulse && !background_debug_mode) begin
                pre_cnt_q <= pre_cnt_q + 7'h01;
            end
            if (wr_count) begin
                count_q <= tcpp_pkg::RST_COUNT;
                down_q <= 1'b0;
                pre_cnt_q <= '0;
            end else if (tick) begin
                if (center_q) begin
                    if (!down_q && at_top) begin
                        down_q <= 1'b1;
                        count_q <= count_q - 16'h0001;
                    end else if (down_q && count_q == 16'h0000) begin
                        down_q <= 1'b0;
                        count_q <= count_q + 16'h0001;
                    end else begin
                        count_q <= down_q ? count_q - 16'h0001 : count_q + 16'h0001;
                    end
                end else begin
                    down_q <= 1'b0;
                    count_q <= at_top ? 16'h0000 : count_q + 16'h0001;
                end
            end
        end
    end

    // ========================================
    // Channels
    logic [NUM_CH-1:0] pin_sel_in;
    logic [NUM_CH-1:0] pin_sync;
    logic [NUM_CH-1:0] ch_capture;
    logic [NUM_CH-1:0] ch_flag_evt;
    logic [NUM_CH-1:0] ch_out;
    logic [NUM_CH-1:0] ch_oe;
    logic [NUM_CH-1:0] wr_ch_ctrl;
    logic [NUM_CH-1:0] wr_ch_value;
    logic [NUM_CH-1:0] ch_ie;

    assign pin_sel_in = (pinpos_q & pin_alt_in) | (~pinpos_q & pin_def_in);

    tcpp_sync #(.WIDTH(NUM_CH)) u_sync_pins (
        .ref_clk(ref_clk),
        .rst(rst),
        .ce(ce),
        .async_in(pin_sel_in),
        .sync_out(pin_sync)
    );

    for (genvar n = 0; n < NUM_CH; n++) begin : g_ch
        localparam logic [7:0] CH_OFF = 8'(tcpp_pkg::OFF_CH_BASE + n * tcpp_pkg::OFF_CH_STRIDE);
        assign wr_ch_ctrl[n] = do_write && (awaddr_q == CH_OFF);
        assign wr_ch_value[n] = do_write && (awaddr_q == CH_OFF + tcpp_pkg::OFF_CH_VALUE);
        assign ch_ie[n] = ch_cfg_q[n].ie;

        tcpp_channel u_ch (
            .ref_clk(ref_clk),
            .rst(rst),
            .ce(ce),
            .cfg(ch_cfg_q[n]),
            .cnt(cnt_bus),
            .value(ch_value_q[n]),
            .pin_sync(pin_sync[n]),
            .capture_evt(ch_capture[n]),
            .flag_evt(ch_flag_evt[n]),
            .pin_out(ch_out[n]),
            .pin_oe(ch_oe[n])
        );

        always_ff @(posedge ref_clk) begin
            if (rst) begin
                ch_cfg_q[n] <= '0;
                ch_value_q[n] <= tcpp_pkg::RST_VALUE;
                ch_flag_q[n] <= 1'b0;
            end else if (ce) begin
                if (wr_ch_ctrl[n]) begin
                    ch_cfg_q[n].mode <= wr_word[tcpp_pkg::CH_MODE_LSB +: 2];
                    ch_cfg_q[n].els <= wr_word[tcpp_pkg::CH_ELS_LSB +: 2];
                    ch_cfg_q[n].ie <= wr_word[tcpp_pkg::CH_IE_BIT];
                end
                if (ch_capture[n]) begin
                    ch_value_q[n] <= count_q;
                end else if (wr_ch_value[n]) begin
                    ch_value_q[n] <= wr_word[15:0];
                end
                // Set beats a same-cycle software clear
                if (ch_flag_evt[n]) begin
                    ch_flag_q[n] <= 1'b1;
                end else if (wr_ch_ctrl[n] && wr_word[tcpp_pkg::CH_FLAG_BIT]) begin
                    ch_flag_q[n] <= 1'b0;
                end
            end
        end
    end

    assign pin_def_out = ch_out;
    assign pin_alt_out = ch_out;
    assign pin_def_oe = ch_oe & ~pinpos_q;
    assign pin_alt_oe = ch_oe & pinpos_q;
    assign channel_irq = ch_flag_q & ch_ie;
    assign overflow_irq = ovf_flag_q && ovf_ie_q;

    // ========================================
    // Global registers and bus handshake
    logic [31:0] ctrl_word;

    assign ctrl_word = {24'h000000, ovf_flag_q, ovf_ie_q, center_q, clksel_q, presc_q};
    assign wr_word = merge(32'h00000000, wdata_q, wstrb_q);
    assign wr_known = wr_ctrl || wr_count || wr_modulo || wr_pinpos ||
        (|wr_ch_ctrl) || (|wr_ch_value);

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= tcpp_pkg::RESP_OKAY;
        end else if (ce) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_q <= 1'b1;
                awaddr_q <= {s_axi_awaddr[7:2], 2'h0};
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_held_q <= 1'b0;
                w_held_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_known ? tcpp_pkg::RESP_OKAY : tcpp_pkg::RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            presc_q <= 3'h0;
            clksel_q <= tcpp_pkg::CLK_OFF;
            center_q <= 1'b0;
            ovf_ie_q <= 1'b0;
            ovf_flag_q <= 1'b0;
            modulo_q <= tcpp_pkg::RST_MODULO;
            pinpos_q <= '0;
        end else if (ce) begin
            if (wr_ctrl && wstrb_q[0]) begin
                presc_q <= wdata_q[tcpp_pkg::CTRL_PRESC_LSB +: 3];
                clksel_q <= wdata_q[tcpp_pkg::CTRL_CLKSEL_LSB +: 2];
                center_q <= wdata_q[tcpp_pkg::CTRL_CENTER_BIT];
                ovf_ie_q <= wdata_q[tcpp_pkg::CTRL_OVF_IE_BIT];
            end
            if (ovf_evt) begin
                ovf_flag_q <= 1'b1;
            end else if (wr_ctrl && wstrb_q[0] && wdata_q[tcpp_pkg::CTRL_OVF_FLAG_BIT]) begin
                ovf_flag_q <= 1'b0;
            end
            if (wr_modulo) begin
                modulo_q <= wr_word[15:0] | (modulo_q & ~strb_mask16(wstrb_q));
            end
            if (wr_pinpos && wstrb_q[0]) begin
                pinpos_q <= wdata_q[NUM_CH-1:0];
            end
        end
    end

    function automatic logic [15:0] strb_mask16(input logic [3:0] strb);
        return {{8{strb[1]}}, {8{strb[0]}}};
    endfunction

    // ========================================
    // Read path
    logic [31:0] rd_word;
    logic rd_known;
    logic [7:0] ra;

    assign ra = {s_axi_araddr[7:2], 2'h0};
    assign s_axi_arready = !s_axi_rvalid;

    always_comb begin
        rd_word = 32'h00000000;
        rd_known = 1'b1;
        if (ra == tcpp_pkg::OFF_CTRL) begin
            rd_word = ctrl_word;
        end else if (ra == tcpp_pkg::OFF_COUNT) begin
            rd_word = {16'h0000, count_q};
        end else if (ra == tcpp_pkg::OFF_MODULO) begin
            rd_word = {16'h0000, modulo_q};
        end else if (ra == tcpp_pkg::OFF_PINPOS) begin
            rd_word = 32'(pinpos_q);
        end else begin
            rd_known = 1'b0;
            for (int k = 0; k < NUM_CH; k++) begin
                if (ra == 8'(tcpp_pkg::OFF_CH_BASE + k * tcpp_pkg::OFF_CH_STRIDE)) begin
                    rd_word = {26'h0000000, ch_flag_q[k], ch_cfg_q[k].ie,
                               ch_cfg_q[k].els, ch_cfg_q[k].mode};
                    rd_known = 1'b1;
                end
                if (ra == 8'(tcpp_pkg::OFF_CH_BASE + k * tcpp_pkg::OFF_CH_STRIDE
                             + tcpp_pkg::OFF_CH_VALUE)) begin
                    rd_word = {16'h0000, ch_value_q[k]};
                    rd_known = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= tcpp_pkg::RESP_OKAY;
        end else if (ce) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_word;
                s_axi_rresp <= rd_known ? tcpp_pkg::RESP_OKAY : tcpp_pkg::RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule // tcpp_top

//--- tcpp_pkg.sv
// Purpose: Shared constants and carrier types of the timer capture compare pwm block
// Assumes: 32-bit AXI4-Lite register bus, 16-bit counter
// Notes: Offsets are byte addresses
package tcpp_pkg;
    // ========================================
    // Register map
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_COUNT = 8'h04;
    localparam logic [7:0] OFF_MODULO = 8'h08;
    localparam logic [7:0] OFF_PINPOS = 8'h0C;
    localparam logic [7:0] OFF_CH_BASE = 8'h10;
    localparam logic [7:0] OFF_CH_STRIDE = 8'h08;
    localparam logic [7:0] OFF_CH_VALUE = 8'h04;
    // ========================================
    // Control register fields
    localparam int CTRL_PRESC_LSB = 0;
    localparam int CTRL_CLKSEL_LSB = 3;
    localparam int CTRL_CENTER_BIT = 5;
    localparam int CTRL_OVF_IE_BIT = 6;
    localparam int CTRL_OVF_FLAG_BIT = 7;
    // ========================================
    // Channel control fields
    localparam int CH_MODE_LSB = 0;
    localparam int CH_ELS_LSB = 2;
    localparam int CH_IE_BIT = 4;
    localparam int CH_FLAG_BIT = 5;
    // ========================================
    // Reset values and full count
    localparam logic [15:0] RST_MODULO = 16'h0000;
    localparam logic [15:0] RST_COUNT = 16'h0000;
    localparam logic [15:0] RST_VALUE = 16'h0000;
    localparam logic [15:0] COUNT_FULL = 16'hFFFF;
    // ========================================
    // Encodings
    localparam logic [1:0] CLK_OFF = 2'h0;
    localparam logic [1:0] CLK_BUS = 2'h1;
    localparam logic [1:0] CLK_FIXED = 2'h2;
    localparam logic [1:0] CLK_EXT = 2'h3;
    localparam logic [1:0] MODE_CAPTURE = 2'h0;
    localparam logic [1:0] MODE_COMPARE = 2'h1;
    localparam logic [1:0] ELS_OFF = 2'h0;
    localparam logic [1:0] ELS_RISE = 2'h1;
    localparam logic [1:0] ELS_FALL = 2'h2;
    localparam logic [1:0] ELS_BOTH = 2'h3;
    localparam logic [1:0] OC_TOGGLE = 2'h1;
    localparam logic [1:0] OC_CLEAR = 2'h2;
    localparam logic [1:0] OC_SET = 2'h3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [1:0] mode;
        logic [1:0] els;
        logic ie;
    } tcpp_ch_cfg_type;

    typedef struct packed {
        logic [15:0] count;
        logic advanced;
        logic down;
        logic center;
        logic enabled;
    } tcpp_cnt_type;
endpackage

//--- tcpp_sync.sv
// Purpose: Two-flop synchroniser for pin inputs
// Assumes: Destination is ref_clk
// Notes: Only the second stage is visible outside
`timescale 1ns/1ps
module tcpp_sync #(
    parameter int WIDTH = 1
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            meta_q <= '0;
            sync_out <= '0;
        end else if (ce) begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule // tcpp_sync

//--- tcpp_channel.sv
// Purpose: One timer channel: capture, compare, edge or center pwm
// Assumes: Pin input already synchronised; counter state from the top
// Notes: Matches count only on the cycle after the counter moved
`timescale 1ns/1ps
module tcpp_channel (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic ce,
    input wire tcpp_pkg::tcpp_ch_cfg_type cfg,
    input wire tcpp_pkg::tcpp_cnt_type cnt,
    input wire logic [15:0] value,
    input wire logic pin_sync,
    output logic capture_evt,
    output logic flag_evt,
    output logic pin_out,
    output logic pin_oe
);
    logic pin_prev_q;
    logic out_q;
    logic out_d;
    logic hit;
    logic start;
    logic rise;
    logic fall;
    logic edge_aligned_pulse;

    assign hit = cnt.advanced && (cnt.count == value);
    assign start = cnt.advanced && (cnt.count == 16'h0000);
    assign rise = pin_sync && !pin_prev_q;
    assign fall = !pin_sync && pin_prev_q;
    assign edge_aligned_pulse = cfg.mode[1];

    assign capture_evt = !cnt.center && (cfg.mode == tcpp_pkg::MODE_CAPTURE) &&
        (((cfg.els == tcpp_pkg::ELS_RISE) && rise) ||
         ((cfg.els == tcpp_pkg::ELS_FALL) && fall) ||
         ((cfg.els == tcpp_pkg::ELS_BOTH) && (rise || fall)));

    assign flag_evt = capture_evt || (hit && (cnt.center || cfg.mode != tcpp_pkg::MODE_CAPTURE));

    assign pin_oe = cnt.enabled && (cfg.els != tcpp_pkg::ELS_OFF) &&
        (cnt.center || cfg.mode != tcpp_pkg::MODE_CAPTURE);
    assign pin_out = out_q;

    always_comb begin
        out_d = out_q;
        if (cnt.center) begin
            if (hit) begin
                out_d = cnt.down ? !cfg.els[0] : cfg.els[0];
            end
        end else if (edge_aligned_pulse) begin
            if (start) begin
                out_d = !cfg.els[0];
            end
            if (hit) begin
                out_d = cfg.els[0];
            end
        end else if (cfg.mode == tcpp_pkg::MODE_COMPARE && hit) begin
            unique case (cfg.els)
                tcpp_pkg::OC_TOGGLE: out_d = !out_q;
                tcpp_pkg::OC_CLEAR: out_d = 1'b0;
                tcpp_pkg::OC_SET: out_d = 1'b1;
                tcpp_pkg::ELS_OFF: out_d = out_q;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pin_prev_q <= 1'b0;
            out_q <= 1'b0;
        end else if (ce) begin
            pin_prev_q <= pin_sync;
            out_q <= out_d;
        end
    end
endmodule // tcpp_channel

//--- tcpp_pin_model.sv
// Purpose: pin side model; Assumes: ref_clk; Notes: pulse on fire
`timescale 1ns/1ps
module tcpp_pin_model (
    input wire logic ref_clk,
    input wire logic fire,
    input wire logic [1:0] oe,
    input wire logic [1:0] out,
    output logic [1:0] pin_in
);
    logic [2:0] hold_q = 3'h0;
    always_ff @(posedge ref_clk) begin
        hold_q <= fire ? 3'h6 : hold_q - {2'h0, hold_q != 3'h0};
    end
    // Driven pins read back what the timer drives
    assign pin_in = (oe & out) | (~oe & {2{hold_q != 3'h0}});
endmodule // tcpp_pin_model

//--- tcpp_monitor.sv
// Purpose: timer port checks; Assumes: one clock; Notes: bound to tcpp_top
`timescale 1ns/1ps
module tcpp_monitor #(
    parameter int NUM_CH = 2
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic background_debug_mode,
    input wire logic [NUM_CH-1:0] pin_def_out,
    input wire logic [NUM_CH-1:0] pin_def_oe,
    input wire logic [NUM_CH-1:0] pin_alt_out,
    input wire logic [NUM_CH-1:0] pin_alt_oe,
    input wire logic [NUM_CH-1:0] channel_irq,
    input wire logic overflow_irq,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    chk_rst_idle: assert property ($fell(rst) |-> !(|{pin_def_oe, pin_alt_oe}))
        else $error("pin driven after reset");
    chk_irq_idle: assert property ($fell(rst) |-> !(|{channel_irq, overflow_irq}))
        else $error("irq after reset");
    chk_pin_one_side: assert property (!(|(pin_def_oe & pin_alt_oe)))
        else $error("both pins driven");
    chk_pin_same: assert property (pin_def_out == pin_alt_out)
        else $error("pin outputs differ");
    chk_debug_hold: assert property (background_debug_mode [*3] |-> $stable(pin_def_out))
        else $error("output moved in debug");
    chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered");
    chk_read_drop: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read answer stuck");
    chk_read_cause: assert property ($rose(s_axi_rvalid) |-> $past(s_axi_arvalid))
        else $error("read answer uncaused");
    cover property (s_axi_rvalid && s_axi_rready);
    cover property (overflow_irq);
    cover property (|channel_irq);
endmodule // tcpp_monitor
bind tcpp_top tcpp_monitor #(.NUM_CH(NUM_CH)) u_monitor (.*);

//--- tb.sv
// Purpose: timer bench; Assumes: two channels; Notes: extra clocks tied off
`timescale 1ns/1ps
module tb;
    logic ref_clk = 1'h0, rst = 1'h1, ce = 1'h1, background_debug_mode = 1'h0, fire = 1'h0;
    logic fixed_clk = 1'h0, external_count_clock = 1'h0, overflow_irq;
    logic [1:0] pin_def_in, pin_alt_in, pin_def_out, pin_def_oe, pin_alt_out, pin_alt_oe;
    logic [1:0] channel_irq, s_axi_bresp, s_axi_rresp, resp;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, data;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
    logic s_axi_rready = 1'h0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid;
    logic [7:0] ra [5] = '{8'h00, 8'h08, 8'h0C, 8'h14, 8'h40};
    logic [31:0] rw [5] = '{32'h0, 32'h1234, 32'h0, 32'hBEEF, 32'h5};
    logic [31:0] re [5] = '{32'h0, 32'h1234, 32'h0, 32'hBEEF, 32'h0};
    logic [1:0] rr [5] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h2};
    logic [31:0] cc [3] = '{32'h30, 32'h38, 32'h34};
    logic ci [3] = '{1'h0, 1'h1, 1'h1};
    int err_count = 0, num_checks = 0, n, i;
    tcpp_top #(.NUM_CH(2)) DUT (.*);
    tcpp_pin_model u_pins (.ref_clk(ref_clk), .fire(fire), .oe(pin_def_oe | pin_alt_oe),
        .out(pin_def_out), .pin_in(pin_def_in));
    assign pin_alt_in = pin_def_in;
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %0t seen %h want %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Ready sampled a half cycle early; inputs only change after posedge
    task automatic step();
        @(negedge ref_clk);
        n++;
        if (n > 200) begin
            err_count++;
            give_verdict();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        n = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do step(); while (!(s_axi_awready && s_axi_wready));
        @(posedge ref_clk);
        {s_axi_awvalid, s_axi_wvalid} <= 2'h0;
        do step(); while (!s_axi_bvalid);
        resp = s_axi_bresp;
        @(posedge ref_clk);
        s_axi_bready <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge ref_clk);
        n = 0;
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do step(); while (!s_axi_arready);
        @(posedge ref_clk);
        s_axi_arvalid <= 1'h0;
        do step(); while (!s_axi_rvalid);
        data = s_axi_rdata;
        resp = s_axi_rresp;
        @(posedge ref_clk);
        s_axi_rready <= 1'h0;
    endtask
    initial forever #10 ref_clk = ~ref_clk;
    initial begin
        repeat (4) @(posedge ref_clk);
        rst <= 1'h0;
        @(negedge ref_clk);
        check({pin_def_oe, pin_alt_oe, channel_irq, overflow_irq}, 32'h0);
        for (i = 0; i < 5; i++) begin
            wr(ra[i], rw[i]);
            check(resp, rr[i]);
            rd(ra[i]);
            check(data, re[i]);
            check(resp, rr[i]);
        end
        $display("register table done");
        wr(8'h00, 32'h08);
        background_debug_mode <= 1'h1;
        wr(8'h04, 32'hFFFF);
        rd(8'h04);
        check(data, 32'h0);
        rd(8'h04);
        check(data, 32'h0);
        background_debug_mode <= 1'h0;
        $display("debug test done");
        wr(8'h08, 32'h4);
        wr(8'h1C, 32'h2);
        wr(8'h18, 32'h0A);
        wr(8'h00, 32'h48);
        wr(8'h04, 32'h0);
        data = 32'h0;
        repeat (6) @(negedge ref_clk);
        repeat (10) begin
            @(negedge ref_clk);
            data = data + pin_def_out[1];
        end
        check(data, 32'h4);
        check({pin_alt_oe, pin_def_oe, overflow_irq}, 32'h5);
        wr(8'h0C, 32'h2);
        @(negedge ref_clk);
        check({pin_alt_oe, pin_def_oe}, 32'h8);
        $display("pwm test done");
        for (i = 0; i < 3; i++) begin
            wr(8'h10, cc[i]);
            fire <= 1'h1;
            @(posedge ref_clk);
            fire <= 1'h0;
            repeat (12) @(negedge ref_clk);
            check(channel_irq[0], ci[i]);
        end
        $display("capture test done");
        wr(8'h00, 32'h68);
        data = 32'h0;
        repeat (10) @(negedge ref_clk);
        repeat (16) begin
            @(negedge ref_clk);
            data = data + pin_alt_out[1];
        end
        check(data, 32'h8);
        $display("center test done");
        give_verdict();
    end
endmodule // tb
